// file: inc/period_match_timer8_pkg.sv
/*
 Constants, field layouts and carrier types of the 8-bit period match timer.
 Assumes a single 40 MHz clock that also serves as the instruction clock.
*/
package period_match_timer8_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_COUNT = 8'h11;
    localparam logic [7:0] IDX_CONTROL = 8'h12;
    localparam logic [7:0] IDX_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_PERIOD = 8'h92;
    localparam logic [7:0] IDX_STATUS = 8'hC0;
    localparam logic [7:0] IDX_MASK = 8'hC1;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [6:0] RST_CONTROL = 7'h00;
    localparam logic RST_FLAG = 1'h0;
    localparam logic [1:0] RST_STATUS = 2'h0;
    localparam int MATCH_FLAG_BIT = 1;
    localparam int STAT_MATCH_BIT = 0;
    localparam int STAT_POST_BIT = 1;

    // ------------------------------------------------------------
    // Prescaler terminal counts and bus responses
    // ------------------------------------------------------------
    localparam logic [3:0] PRE_LAST_1 = 4'h0;
    localparam logic [3:0] PRE_LAST_4 = 4'h3;
    localparam logic [3:0] PRE_LAST_16 = 4'hF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] postscale;
        logic run;
        logic [1:0] prescale;
    } control_t;

    typedef struct packed {
        logic [7:0] count;
        logic periodMatch;
    } pwm_link_t;

    typedef enum logic {
        WR_COLLECT = 1'b0,
        WR_RESPOND = 1'b1
    } wr_state_t;

    typedef enum logic {
        RD_IDLE = 1'b0,
        RD_RESPOND = 1'b1
    } rd_state_t;

endpackage

// file: src/period_match_timer8.sv
/*
 8-bit period match timer with prescaler, postscaler, interrupt flag,
 AXI4-Lite register slave and links to the serial port and PWM unit.
 Assumes one clock, synchronous active-high reset, one access per channel.
*/
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module period_match_timer8 (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [period_match_timer8_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [period_match_timer8_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic irq,
    output logic sspShiftClock,
    output period_match_timer8_pkg::pwm_link_t pwmLink
);

    // ------------------------------------------------------------
    // Address helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] toIndex(
        input logic [period_match_timer8_pkg::ADDR_W-1:0] addr
    );
        toIndex = addr[period_match_timer8_pkg::ADDR_W-1:2];
    endfunction

    function automatic logic isMapped(input logic [7:0] idx);
        isMapped = (idx == period_match_timer8_pkg::IDX_FLAGS)
            || (idx == period_match_timer8_pkg::IDX_COUNT)
            || (idx == period_match_timer8_pkg::IDX_CONTROL)
            || (idx == period_match_timer8_pkg::IDX_ENABLES)
            || (idx == period_match_timer8_pkg::IDX_PERIOD)
            || (idx == period_match_timer8_pkg::IDX_STATUS)
            || (idx == period_match_timer8_pkg::IDX_MASK);
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    period_match_timer8_pkg::wr_state_t wrState_reg;
    period_match_timer8_pkg::wr_state_t wrState_next;
    period_match_timer8_pkg::rd_state_t rdState_reg;
    period_match_timer8_pkg::rd_state_t rdState_next;
    logic awHeld_reg;
    logic awHeld_next;
    logic wHeld_reg;
    logic wHeld_next;
    logic [7:0] wrIdx_reg;
    logic [7:0] wrIdx_next;
    logic [7:0] wrData_reg;
    logic [7:0] wrData_next;
    logic wrLane_reg;
    logic wrLane_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;

    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [7:0] period_reg;
    logic [7:0] period_next;
    period_match_timer8_pkg::control_t control_reg;
    period_match_timer8_pkg::control_t control_next;
    logic matchPulse_reg;
    logic matchPulse_next;
    logic flag_reg;
    logic flag_next;
    logic enable_reg;
    logic enable_next;
    logic [1:0] status_reg;
    logic [1:0] status_next;
    logic [1:0] mask_reg;
    logic [1:0] mask_next;

    logic wrFire;
    logic countWr;
    logic controlWr;
    logic periodWr;
    logic flagsWr;
    logic enablesWr;
    logic maskWr;
    logic rdFire;
    logic [7:0] rdIdx;
    logic statusRd;
    logic preClear;
    logic tick;
    logic atPeriod;
    logic rollOver;
    logic postEvent;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    // Address and data are taken in either order, then written together.
    assign awready = !awHeld_reg && (wrState_reg == period_match_timer8_pkg::WR_COLLECT);
    assign wready = !wHeld_reg && (wrState_reg == period_match_timer8_pkg::WR_COLLECT);
    assign bvalid = (wrState_reg == period_match_timer8_pkg::WR_RESPOND);
    assign bresp = bresp_reg;
    assign wrFire = (wrState_reg == period_match_timer8_pkg::WR_COLLECT)
        && awHeld_reg && wHeld_reg;

    always_comb begin
        wrState_next = wrState_reg;
        awHeld_next = awHeld_reg;
        wHeld_next = wHeld_reg;
        wrIdx_next = wrIdx_reg;
        wrData_next = wrData_reg;
        wrLane_next = wrLane_reg;
        bresp_next = bresp_reg;
        case (wrState_reg)
            period_match_timer8_pkg::WR_COLLECT: begin
                if (awvalid && awready) begin
                    awHeld_next = 1'b1;
                    wrIdx_next = toIndex(awaddr);
                end
                if (wvalid && wready) begin
                    wHeld_next = 1'b1;
                    wrData_next = wdata[7:0];
                    wrLane_next = wstrb[0];
                end
                if (wrFire) begin
                    awHeld_next = 1'b0;
                    wHeld_next = 1'b0;
                    wrState_next = period_match_timer8_pkg::WR_RESPOND;
                    bresp_next = isMapped(wrIdx_reg)
                        ? period_match_timer8_pkg::RESP_OKAY
                        : period_match_timer8_pkg::RESP_SLVERR;
                end
            end
            period_match_timer8_pkg::WR_RESPOND: begin
                if (bready) begin
                    wrState_next = period_match_timer8_pkg::WR_COLLECT;
                end
            end
            default: begin
                wrState_next = period_match_timer8_pkg::WR_COLLECT;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wrState_reg <= period_match_timer8_pkg::WR_COLLECT;
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            wrIdx_reg <= 8'h00;
            wrData_reg <= 8'h00;
            wrLane_reg <= 1'b0;
            bresp_reg <= period_match_timer8_pkg::RESP_OKAY;
        end else begin
            wrState_reg <= wrState_next;
            awHeld_reg <= awHeld_next;
            wHeld_reg <= wHeld_next;
            wrIdx_reg <= wrIdx_next;
            wrData_reg <= wrData_next;
            wrLane_reg <= wrLane_next;
            bresp_reg <= bresp_next;
        end
    end

    // Byte lane 0 carries every register; other lanes are ignored.
    assign countWr = wrFire && wrLane_reg
        && (wrIdx_reg == period_match_timer8_pkg::IDX_COUNT);
    assign controlWr = wrFire && wrLane_reg
        && (wrIdx_reg == period_match_timer8_pkg::IDX_CONTROL);
    assign periodWr = wrFire && wrLane_reg
        && (wrIdx_reg == period_match_timer8_pkg::IDX_PERIOD);
    assign flagsWr = wrFire && wrLane_reg
        && (wrIdx_reg == period_match_timer8_pkg::IDX_FLAGS);
    assign enablesWr = wrFire && wrLane_reg
        && (wrIdx_reg == period_match_timer8_pkg::IDX_ENABLES);
    assign maskWr = wrFire && wrLane_reg
        && (wrIdx_reg == period_match_timer8_pkg::IDX_MASK);

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    assign arready = (rdState_reg == period_match_timer8_pkg::RD_IDLE);
    assign rvalid = (rdState_reg == period_match_timer8_pkg::RD_RESPOND);
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign rdFire = arvalid && arready;
    assign rdIdx = toIndex(araddr);
    assign statusRd = rdFire && (rdIdx == period_match_timer8_pkg::IDX_STATUS);

    always_comb begin
        rdState_next = rdState_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        case (rdState_reg)
            period_match_timer8_pkg::RD_IDLE: begin
                if (rdFire) begin
                    rdState_next = period_match_timer8_pkg::RD_RESPOND;
                    rresp_next = period_match_timer8_pkg::RESP_OKAY;
                    rdata_next = 32'h0000_0000;
                    case (rdIdx)
                        period_match_timer8_pkg::IDX_FLAGS: begin
                            rdata_next[period_match_timer8_pkg::MATCH_FLAG_BIT] = flag_reg;
                        end
                        period_match_timer8_pkg::IDX_COUNT: begin
                            rdata_next[7:0] = count_reg;
                        end
                        period_match_timer8_pkg::IDX_CONTROL: begin
                            rdata_next[6:0] = control_reg;
                        end
                        period_match_timer8_pkg::IDX_ENABLES: begin
                            rdata_next[period_match_timer8_pkg::MATCH_FLAG_BIT] = enable_reg;
                        end
                        period_match_timer8_pkg::IDX_PERIOD: begin
                            rdata_next[7:0] = period_reg;
                        end
                        period_match_timer8_pkg::IDX_STATUS: begin
                            rdata_next[1:0] = status_reg;
                        end
                        period_match_timer8_pkg::IDX_MASK: begin
                            rdata_next[1:0] = mask_reg;
                        end
                        default: begin
                            rresp_next = period_match_timer8_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            period_match_timer8_pkg::RD_RESPOND: begin
                if (rready) begin
                    rdState_next = period_match_timer8_pkg::RD_IDLE;
                end
            end
            default: begin
                rdState_next = period_match_timer8_pkg::RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdState_reg <= period_match_timer8_pkg::RD_IDLE;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= period_match_timer8_pkg::RESP_OKAY;
        end else begin
            rdState_reg <= rdState_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // ------------------------------------------------------------
    // Timer core
    // ------------------------------------------------------------
    // count or control write restarts both dividers
    assign preClear = countWr || controlWr;

    prescale_divider u_prescale (
        .clock(clock),
        .sys_rst(sys_rst),
        .clearCount(preClear),
        .run(control_reg.run),
        .select(control_reg.prescale),
        .tick(tick)
    );

    assign atPeriod = (count_reg == period_reg);
    assign rollOver = tick && atPeriod && !countWr;

    always_comb begin
        count_next = count_reg;
        period_next = period_reg;
        control_next = control_reg;
        matchPulse_next = 1'b0;
        // software write wins over a tick
        if (countWr) begin
            count_next = wrData_reg;
        end else if (tick) begin
            if (atPeriod) begin
                count_next = 8'h00;
                matchPulse_next = 1'b1;
            end else begin
                count_next = count_reg + 8'h01;
            end
        end
        if (controlWr) begin
            control_next = wrData_reg[6:0];
        end
        if (periodWr) begin
            period_next = wrData_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_reg <= period_match_timer8_pkg::RST_COUNT;
            period_reg <= period_match_timer8_pkg::RST_PERIOD;
            control_reg <= period_match_timer8_pkg::RST_CONTROL;
            matchPulse_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            period_reg <= period_next;
            control_reg <= control_next;
            matchPulse_reg <= matchPulse_next;
        end
    end

    postscale_divider u_postscale (
        .clock(clock),
        .sys_rst(sys_rst),
        .clearCount(preClear),
        .matchIn(rollOver),
        .select(control_reg.postscale),
        .eventOut(postEvent)
    );

    // ------------------------------------------------------------
    // Outputs to the serial port and PWM unit
    // ------------------------------------------------------------
    // pre-postscaler match pulse
    assign sspShiftClock = matchPulse_reg;
    assign pwmLink.count = count_reg;
    assign pwmLink.periodMatch = matchPulse_reg;

    // ------------------------------------------------------------
    // Interrupt flags, enables, sticky status and mask
    // ------------------------------------------------------------
    always_comb begin
        flag_next = flag_reg;
        enable_next = enable_reg;
        status_next = status_reg;
        mask_next = mask_reg;
        if (flagsWr) begin
            flag_next = wrData_reg[period_match_timer8_pkg::MATCH_FLAG_BIT];
        end
        if (postEvent) begin
            flag_next = 1'b1;
        end
        if (enablesWr) begin
            enable_next = wrData_reg[period_match_timer8_pkg::MATCH_FLAG_BIT];
        end
        if (maskWr) begin
            mask_next = wrData_reg[1:0];
        end
        // Read clears; a same-cycle event stays set
        if (statusRd) begin
            status_next = 2'h0;
        end
        if (rollOver) begin
            status_next[period_match_timer8_pkg::STAT_MATCH_BIT] = 1'b1;
        end
        if (postEvent) begin
            status_next[period_match_timer8_pkg::STAT_POST_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            // flags and enables reset to zero
            flag_reg <= period_match_timer8_pkg::RST_FLAG;
            enable_reg <= period_match_timer8_pkg::RST_FLAG;
            status_reg <= period_match_timer8_pkg::RST_STATUS;
            mask_reg <= period_match_timer8_pkg::RST_STATUS;
        end else begin
            flag_reg <= flag_next;
            enable_reg <= enable_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
        end
    end

    assign irq = (flag_reg && enable_reg) || (|(status_reg & mask_reg));

endmodule

// file: src/postscale_divider.sv
/*
 Postscaler for the period match timer: one event per select plus one matches.
 Assumes matchIn is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
module postscale_divider (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clearCount,
    input wire logic matchIn,
    input wire logic [3:0] select,
    output logic eventOut
);
    logic [3:0] count_reg;
    logic [3:0] count_next;

    always_comb begin
        eventOut = matchIn && (count_reg == select);
        count_next = count_reg;
        if (clearCount) begin
            count_next = 4'h0;
        end else if (eventOut) begin
            count_next = 4'h0;
        end else if (matchIn) begin
            count_next = count_reg + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_reg <= 4'h0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

// file: src/prescale_divider.sv
/*
 Prescaler for the period match timer: turns the clock into count ticks.
 Assumes the owner clears it on count or control writes.
*/
`timescale 1ns/1ps
module prescale_divider (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clearCount,
    input wire logic run,
    input wire logic [1:0] select,
    output logic tick
);
    logic [3:0] count_reg;
    logic [3:0] count_next;
    logic [3:0] last;

    always_comb begin
        if (select[1]) begin
            last = period_match_timer8_pkg::PRE_LAST_16;
        end else if (select[0]) begin
            last = period_match_timer8_pkg::PRE_LAST_4;
        end else begin
            last = period_match_timer8_pkg::PRE_LAST_1;
        end
        tick = run && (count_reg == last);
        count_next = count_reg;
        if (clearCount) begin
            count_next = 4'h0;
        end else if (tick) begin
            count_next = 4'h0;
        end else if (run) begin
            count_next = count_reg + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_reg <= 4'h0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

// file: verification/far_side_model.sv
/*
 Serial port and PWM unit seen from the timer: counts shift clocks, times periods.
 Assumes the timer clock and reset.
*/
`timescale 1ns/1ps
module far_side_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic shiftClock,
    input wire period_match_timer8_pkg::pwm_link_t pwmLink,
    output logic [15:0] pulseCount,
    output logic [15:0] lastGap
);
    logic [15:0] since;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pulseCount <= 16'h0;
            lastGap <= 16'h0;
            since <= 16'h0;
        end else begin
            since <= since + 16'h1;
            if (shiftClock)
                pulseCount <= pulseCount + 16'h1;
            if (pwmLink.periodMatch) begin
                lastGap <= since + 16'h1;
                since <= 16'h0;
            end
        end
    end
endmodule

// file: verification/testbench.sv
/*
 Self-checking bench of the period match timer.
 Assumes the far side model and the bound checker.
*/
`timescale 1ns/1ps
module testbench;
    logic clock, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, sspShiftClock;
    logic [9:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs, br;
    period_match_timer8_pkg::pwm_link_t pwmLink;
    logic [15:0] pulseCount, lastGap, base;
    int error_cnt = 0;
    int samples_checked = 0;

    period_match_timer8 DUT (.clock(clock), .sys_rst(sys_rst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq),
        .sspShiftClock(sspShiftClock), .pwmLink(pwmLink));
    far_side_model PEER (.clock(clock), .sys_rst(sys_rst), .shiftClock(sspShiftClock),
        .pwmLink(pwmLink), .pulseCount(pulseCount), .lastGap(lastGap));

    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    task automatic complete_run;
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Ready seen at the falling edge still holds at the next rising edge
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        int n;
        n = 0;
        @(posedge clock);
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        do begin
            @(negedge clock);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            br = bresp;
            @(posedge clock);
            if (ta)
                awvalid <= 1'h0;
            if (tw)
                wvalid <= 1'h0;
            n++;
        end while (!tb && n < 40);
        bready <= 1'h0;
        chk({31'h0, tb}, 32'h1);
        chk({30'h0, br}, {30'h0, er});
    endtask

    task automatic rdr(input logic [7:0] idx);
        logic ta, tr;
        int n;
        n = 0;
        @(posedge clock);
        arvalid <= 1'h1;
        rready <= 1'h1;
        araddr <= {idx, 2'h0};
        do begin
            @(negedge clock);
            ta = arvalid && arready;
            tr = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge clock);
            if (ta)
                arvalid <= 1'h0;
            n++;
        end while (!tr && n < 40);
        rready <= 1'h0;
        chk({31'h0, tr}, 32'h1);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        rdr(idx);
        chk(rd, {24'h0, exp});
    endtask

    task automatic waitPulses(input logic [15:0] k);
        int n;
        n = 0;
        base = pulseCount;
        while (pulseCount - base < k && n < 4000) begin
            @(posedge clock);
            n++;
        end
        chk({31'h0, (pulseCount - base >= k)}, 32'h1);
    endtask

    task automatic test_reset;
        rchk(8'h11, 8'h00);
        rchk(8'h92, 8'hFF);
        rchk(8'h12, 8'h00);
        rchk(8'h0C, 8'h00);
        rchk(8'h8C, 8'h00);
        rdr(8'h05);
        chk({30'h0, rs}, {30'h0, period_match_timer8_pkg::RESP_SLVERR});
        wr(8'h05, 8'h01, period_match_timer8_pkg::RESP_SLVERR);
    endtask

    task automatic test_prescale;
        logic [15:0] div [4] = '{16'h1, 16'h4, 16'h10, 16'h10};
        wr(8'h92, 8'h05, 2'h0);
        for (int i = 0; i < 4; i++) begin
            wr(8'h12, 8'h04 + 8'(i), 2'h0);
            waitPulses(16'h2);
            chk({16'h0, lastGap}, {16'h0, div[i] * 16'h6});
        end
        wr(8'h12, 8'h00, 2'h0);
        rdr(8'h11);
        repeat (20) @(posedge clock);
        rchk(8'h11, rd[7:0]);
    endtask

    task automatic test_control;
        wr(8'h11, 8'h40, 2'h0);
        rchk(8'h11, 8'h40);
        wstrb <= 4'hE;
        wr(8'h11, 8'h99, 2'h0);
        wstrb <= 4'hF;
        rchk(8'h11, 8'h40);
        wr(8'h12, 8'hFB, 2'h0);
        rchk(8'h12, 8'h7B);
        rchk(8'h11, 8'h40);
    endtask

    task automatic test_postscale;
        int n;
        n = 0;
        wr(8'h12, 8'h00, 2'h0);
        wr(8'h11, 8'h00, 2'h0);
        wr(8'h0C, 8'h00, 2'h0);
        wr(8'h8C, 8'h02, 2'h0);
        base = pulseCount;
        wr(8'h12, 8'h14, 2'h0);
        while (!irq && n < 400) begin
            @(negedge clock);
            n++;
        end
        chk({31'h0, irq}, 32'h1);
        repeat (2) @(posedge clock);
        chk({16'h0, pulseCount - base}, 32'h3);
        rchk(8'h0C, 8'h02);
        wr(8'h8C, 8'h00, 2'h0);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0);
        wr(8'h12, 8'h00, 2'h0);
        wr(8'h0C, 8'h00, 2'h0);
        rchk(8'h0C, 8'h00);
        rchk(8'hC0, 8'h03);
        rchk(8'hC0, 8'h00);
        wr(8'hC1, 8'h03, 2'h0);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic test_midreset;
        wr(8'h12, 8'h04, 2'h0);
        repeat (10) @(posedge clock);
        sys_rst <= 1'h1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'h0;
        rchk(8'h11, 8'h00);
        rchk(8'h92, 8'hFF);
        rchk(8'h12, 8'h00);
        rchk(8'h8C, 8'h00);
    endtask

    initial begin
        sys_rst = 1'h1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 10'h0;
        araddr = 10'h0;
        wdata = 32'h0;
        wstrb = 4'hF;
        repeat (3) @(posedge clock);
        sys_rst <= 1'h0;
        test_reset();
        test_prescale();
        test_control();
        test_postscale();
        test_midreset();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        complete_run();
    end
endmodule

// file: verification/timer_monitor.sv
/*
 Port checker of the period match timer.
 Assumes it is bound onto period_match_timer8.
*/
`timescale 1ns/1ps
module timer_monitor (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic irq,
    input wire logic sspShiftClock,
    input wire period_match_timer8_pkg::pwm_link_t pwmLink
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    AST_RST: assert property ($fell(sys_rst) |-> awready && arready && !bvalid
        && !rvalid && !irq && pwmLink.count == 8'h00) else $error("bad state after reset");
    AST_WLAT: assert property (awvalid && awready && wvalid && wready
        |=> !awready && !bvalid ##1 bvalid) else $error("write answer late");
    AST_BDONE: assert property (bvalid && bready |=> !bvalid) else $error("bvalid stuck");
    AST_RANS: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
    AST_RHOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    AST_RBLK: assert property (rvalid |-> !arready) else $error("read taken while busy");
    AST_SAME: assert property (sspShiftClock == pwmLink.periodMatch)
        else $error("match pulses differ");
    AST_ZERO: assert property (sspShiftClock |-> pwmLink.count == 8'h00)
        else $error("pulse without rollover");
    AST_STEP: assert property (!bvalid && !$past(bvalid) && $changed(pwmLink.count)
        |-> pwmLink.count == $past(pwmLink.count) + 8'h01 || pwmLink.count == 8'h00)
        else $error("count jumped");
endmodule

bind period_match_timer8 timer_monitor u_mon (.clock(clock), .sys_rst(sys_rst),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .irq(irq),
    .sspShiftClock(sspShiftClock), .pwmLink(pwmLink));
